/* tade_encoder.sv */
// tri-state address/data encoder: request line to serial modulation stream
// assumes pins are read twice, through weak pull-up and pull-down, and latched once per cycle
`timescale 1ns/1ps
`default_nettype none
`include "tade_params.svh"
module tade_encoder
   import tade_pkg::*;
#(
   // quarter-slot length in clocks; a bench may shorten it to keep runs brief
   parameter int QTR_CYC = `TADE_QTR_CYC
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic transmit_request,
   input wire logic [9:0] addr_select_up,
   input wire logic [9:0] addr_select_dn,
   input wire logic [7:0] payload_up,
   input wire logic [7:0] payload_dn,
   output logic tx_data_q,
   output logic tx_active_q
);
   // ********************************
   // input sensing
   // ********************************
   tade_sym_t sym_w [0:17];
   logic [17:0] up_w, dn_w;
   assign up_w = {payload_up, addr_select_up};
   assign dn_w = {payload_dn, addr_select_dn};
   genvar gi;
   generate
      for (gi = 0; gi < `TADE_SYM_N; gi++)
      begin : g_sense
         tade_tri_sense u_sense
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .pin_up(up_w[gi]),
            .pin_dn(dn_w[gi]),
            .sym_q(sym_w[gi])
         );
      end
   endgenerate

   // ********************************
   // request sync and quarter-slot tick
   // ********************************
   logic req1_q, req2_q, req3_q;
   logic [11:0] div_q, div_d;
   logic tick;
   always_comb
   begin
      tick = (div_q == 12'(QTR_CYC - 1));
      div_d = tick ? 12'h000 : div_q + 12'h001;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         req1_q <= 1'b0;
         req2_q <= 1'b0;
         req3_q <= 1'b0;
         div_q <= 12'h000;
      end
      else
      begin
         req1_q <= transmit_request;
         req2_q <= req1_q;
         req3_q <= req2_q;
         div_q <= div_d;
      end
   end
   logic req_rise;
   assign req_rise = req2_q && !req3_q;

   // ********************************
   // framing state machine
   // ********************************
   tade_state_t st_q, st_d;
   logic [35:0] word_q, word_d;
   logic [4:0] sym_q, sym_d;
   logic [1:0] wrd_q, wrd_d, qtr_q, qtr_d;
   logic start_q, start_d;
   logic tx_d, act_d;
   logic [1:0] cur;
   always_comb
   begin
      st_d = st_q;
      word_d = word_q;
      sym_d = sym_q;
      wrd_d = wrd_q;
      qtr_d = qtr_q;
      start_d = start_q;
      tx_d = 1'b0;
      act_d = 1'b0;
      cur = word_q[2*sym_q +: 2];
      // a rising request is remembered so even a short press sends one cycle
      if (req_rise)
         start_d = 1'b1;
      case (st_q)
         TADE_IDLE:
         begin
            if (start_q || req2_q)
               st_d = TADE_LOAD;
         end
         TADE_LOAD:
         begin
            for (int i = 0; i < `TADE_SYM_N; i++)
               word_d[2*i +: 2] = sym_w[i];
            start_d = 1'b0;
            sym_d = 5'h00;
            wrd_d = 2'h0;
            qtr_d = 2'h0;
            // between repeats active holds; from idle it stays low until sending
            act_d = tx_active_q;
            if (tick)
               st_d = TADE_SEND;
         end
         TADE_SEND:
         begin
            act_d = 1'b1;
            // slot: low=1000, high=1110, float=1100 - mean near half mark
            case (qtr_q)
               2'h0: tx_d = 1'b1;
               2'h1: tx_d = (cur != TADE_SYM_LOW);
               2'h2: tx_d = (cur == TADE_SYM_HIGH);
               default: tx_d = 1'b0;
            endcase
            if (tick)
            begin
               qtr_d = qtr_q + 2'h1;
               if (qtr_q == 2'h3)
               begin
                  if (sym_q == 5'(`TADE_SYM_N - 1))
                  begin
                     sym_d = 5'h00;
                     st_d = TADE_GAP;
                  end
                  else
                     sym_d = sym_q + 5'h01;
               end
            end
         end
         TADE_GAP:
         begin
            act_d = 1'b1;
            tx_d = 1'b0;
            if (tick)
            begin
               qtr_d = qtr_q + 2'h1;
               if (qtr_q == 2'h3)
               begin
                  sym_d = sym_q + 5'h01;
                  if (sym_q == 5'(`TADE_GAP_SYM - 1))
                  begin
                     sym_d = 5'h00;
                     if (wrd_q == 2'(`TADE_WORDS - 1))
                     begin
                        // cycle done: repeat or stop, never mid-cycle
                        // a repeat keeps active high so the air sees one unbroken run
                        if (req2_q || start_d)
                           st_d = TADE_LOAD;
                        else
                        begin
                           st_d = TADE_IDLE;
                           act_d = 1'b0;
                        end
                     end
                     else
                     begin
                        wrd_d = wrd_q + 2'h1;
                        st_d = TADE_SEND;
                     end
                  end
               end
            end
         end
         default: st_d = TADE_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= TADE_IDLE;
         word_q <= 36'h0;
         sym_q <= 5'h00;
         wrd_q <= 2'h0;
         qtr_q <= 2'h0;
         start_q <= 1'b0;
         tx_data_q <= 1'b0;
         tx_active_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         word_q <= word_d;
         sym_q <= sym_d;
         wrd_q <= wrd_d;
         qtr_q <= qtr_d;
         start_q <= start_d;
         tx_data_q <= tx_d;
         tx_active_q <= act_d;
      end
   end

   // ********************************
   // checks
   // ********************************
   a_quiet_idle: assert property (@(posedge clk) disable iff (sys_rst)
      (st_q == TADE_IDLE) |=> !tx_data_q)
      else $error("serial output active while idle");
   a_send_from_load: assert property (@(posedge clk) disable iff (sys_rst)
      (st_q == TADE_SEND) |-> ($past(st_q) inside {TADE_SEND, TADE_LOAD, TADE_GAP}))
      else $error("send entered without load");
   a_stop_at_end: assert property (@(posedge clk) disable iff (sys_rst)
      ($past(st_q) == TADE_GAP && st_q == TADE_IDLE) |-> $past(wrd_q) == 2'h2)
      else $error("cycle truncated");
   a_repeat_held: assert property (@(posedge clk) disable iff (sys_rst)
      ($past(st_q) == TADE_GAP && $past(req2_q) && st_q != TADE_GAP) |-> st_q != TADE_IDLE)
      else $error("held request did not repeat");
   a_word_count: assert property (@(posedge clk) disable iff (sys_rst)
      wrd_q <= 2'h2)
      else $error("more than three words");
   a_sym_range: assert property (@(posedge clk) disable iff (sys_rst)
      (st_q == TADE_SEND) |-> sym_q <= 5'd17)
      else $error("symbol index out of range");
   a_slot_lead: assert property (@(posedge clk) disable iff (sys_rst)
      (st_q == TADE_SEND && qtr_q == 2'h0) |=> tx_data_q)
      else $error("slot does not start with mark");
   a_rise_starts: assert property (@(posedge clk) disable iff (sys_rst)
      (req_rise && st_q == TADE_IDLE) |=> ##[0:2] st_q == TADE_LOAD)
      else $error("request edge ignored");
endmodule
`default_nettype wire

/* tade_params.svh */
// timing and framing constants for the tri-state address/data encoder
// assumes a 250 MHz system clock; included by the encoder files
`ifndef TADE_PARAMS_SVH
`define TADE_PARAMS_SVH
`define TADE_CLK_HZ 250000000
`define TADE_BIT_HZ 70000
// one symbol slot divides into four quarters
`define TADE_QTR_CYC ((`TADE_CLK_HZ / (`TADE_BIT_HZ * 4)) > 0 ? (`TADE_CLK_HZ / (`TADE_BIT_HZ * 4)) : 1)
`define TADE_ADDR_N 10
`define TADE_DATA_N 8
`define TADE_SYM_N 18
`define TADE_WORDS 3
`define TADE_GAP_SYM 4
`define TADE_LAG_MS 150
`define TADE_LAG_CYC (`TADE_LAG_MS * (`TADE_CLK_HZ / 1000))
`endif

/* tade_pkg.sv */
// types shared by the encoder
package tade_pkg;
   typedef enum logic [1:0]
   {
      TADE_SYM_LOW = 2'h0,
      TADE_SYM_HIGH = 2'h1,
      TADE_SYM_FLOAT = 2'h2
   } tade_sym_t;
   typedef enum logic [3:0]
   {
      TADE_IDLE = 4'h1,
      TADE_LOAD = 4'h2,
      TADE_SEND = 4'h4,
      TADE_GAP = 4'h8
   } tade_state_t;
endpackage

/* tade_tri_sense.sv */
// one tri-state input sensor: classifies a pin as high, low or floating
// assumes the pad gives one pin reading under weak pull-up and one under weak pull-down
`timescale 1ns/1ps
`default_nettype none
module tade_tri_sense
   import tade_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pin_up,
   input wire logic pin_dn,
   output tade_sym_t sym_q
);
   logic up1_q, up2_q, dn1_q, dn2_q;
   tade_sym_t sym_d;
   always_comb
   begin
      // pulled up reads 1, pulled down reads 0: a driven pin ignores the pull
      if (up2_q && dn2_q)
         sym_d = TADE_SYM_HIGH;
      else if (!up2_q && !dn2_q)
         sym_d = TADE_SYM_LOW;
      else
         sym_d = TADE_SYM_FLOAT;
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         up1_q <= 1'b0;
         up2_q <= 1'b0;
         dn1_q <= 1'b0;
         dn2_q <= 1'b0;
         sym_q <= TADE_SYM_LOW;
      end
      else
      begin
         up1_q <= pin_up;
         up2_q <= up1_q;
         dn1_q <= pin_dn;
         dn2_q <= dn1_q;
         sym_q <= sym_d;
      end
   end
endmodule
`default_nettype wire

/* tade_rx_model.sv */
// receiver-side decoder model for the encoder's serial stream
// assumes the slot shape of the encoder: 4 quarters of QTR clocks
`timescale 1ns/1ps
`default_nettype none
module tade_rx_model
   import tade_pkg::*;
#(
   parameter int QTR = 892
)
(
   input wire logic clk,
   input wire logic tx_data,
   input wire logic [19:0] local_addr,
   output logic [19:0] rx_addr,
   output logic [15:0] rx_data,
   output logic [15:0] rx_words,
   output logic [7:0] rx_out
);
   logic [35:0] sym_word;
   logic a;
   // ****************************
   // slot sampling
   // ****************************
   initial
   begin
      rx_words = 16'h0;
      rx_out = 8'h0;
      rx_addr = 20'h0;
      rx_data = 16'h0;
      forever
      begin
         for (int i = 0; i < 18; i++)
         begin
            // every slot opens with a mark, so its edge re-aligns us
            @(posedge tx_data);
            repeat (QTR + QTR / 2) @(posedge clk);
            a = tx_data;
            repeat (QTR) @(posedge clk);
            sym_word[2*i+:2] = !a ? TADE_SYM_LOW : (tx_data ? TADE_SYM_HIGH : TADE_SYM_FLOAT);
         end
         rx_addr = sym_word[19:0];
         rx_data = sym_word[35:20];
         rx_words = rx_words + 16'h1;
         if (rx_addr == local_addr)
         begin
            for (int j = 0; j < 8; j++)
            begin
               rx_out[j] = (rx_data[2*j+:2] == TADE_SYM_HIGH);
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tristate_address_data_encoder_tb_top.sv */
// testbench for the tri-state encoder with a decoder model on the air side
// assumes a shortened quarter set on both instances to keep the run brief
`timescale 1ns/1ps
`default_nettype none
`include "tade_params.svh"
module tristate_address_data_encoder_tb_top;
   import tade_pkg::*;
   logic clk, sys_rst, transmit_request, tx_data_q, tx_active_q;
   logic [9:0] addr_select_up, addr_select_dn;
   logic [7:0] payload_up, payload_dn, rx_out;
   logic [19:0] local_addr, rx_addr;
   logic [15:0] rx_data, rx_words;
   int failures, tests_run, cyc;
   localparam logic [19:0] ADR = 20'h29861;
   localparam logic [15:0] D1 = 16'h9126;
   localparam logic [15:0] D2 = 16'h5544;
   localparam int QTR = 16;
   localparam int CYC_CLK = `TADE_WORDS * (`TADE_SYM_N + `TADE_GAP_SYM) * 4 * QTR;
   tade_encoder #(.QTR_CYC(QTR)) tade_encoder_inst (.clk(clk), .sys_rst(sys_rst),
      .transmit_request(transmit_request), .addr_select_up(addr_select_up),
      .addr_select_dn(addr_select_dn), .payload_up(payload_up), .payload_dn(payload_dn),
      .tx_data_q(tx_data_q), .tx_active_q(tx_active_q));
   tade_rx_model #(.QTR(QTR)) tade_rx_model_inst (.clk(clk), .tx_data(tx_data_q),
      .local_addr(local_addr), .rx_addr(rx_addr), .rx_data(rx_data),
      .rx_words(rx_words), .rx_out(rx_out));
   // ****************************
   // helpers
   // ****************************
   task automatic results();
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] hi(input logic [15:0] d);
      for (int j = 0; j < 8; j++)
         hi[j] = (d[2*j+:2] == TADE_SYM_HIGH);
   endfunction
   task automatic set_pins(input logic [19:0] a, input logic [15:0] d);
      for (int i = 0; i < 10; i++)
      begin
         addr_select_up[i] = (a[2*i+:2] != TADE_SYM_LOW);
         addr_select_dn[i] = (a[2*i+:2] == TADE_SYM_HIGH);
      end
      for (int i = 0; i < 8; i++)
      begin
         payload_up[i] = (d[2*i+:2] != TADE_SYM_LOW);
         payload_dn[i] = (d[2*i+:2] == TADE_SYM_HIGH);
      end
   endtask
   task automatic wait_active(input logic lvl);
      int n;
      n = 0;
      while (tx_active_q !== lvl && n < 2 * CYC_CLK)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(tx_active_q, lvl);
   endtask
   // ****************************
   // scenarios
   // ****************************
   task automatic pulse_cycle(input logic [19:0] loc, input logic [7:0] exp_out);
      int n, w0;
      set_pins(ADR, D1);
      local_addr = loc;
      w0 = rx_words;
      transmit_request = 1'b1;
      repeat (3) @(posedge clk);
      #1 transmit_request = 1'b0;
      wait_active(1'b1);
      n = 0;
      while (tx_active_q === 1'b1 && n < 2 * CYC_CLK)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(n >= CYC_CLK - 2 && n <= CYC_CLK, 1'b1);
      chk(rx_words - w0, 3);
      chk(rx_addr, ADR);
      chk(rx_data, D1);
      chk(rx_out, exp_out);
   endtask
   task automatic hold_cycles();
      int n, w0, drops;
      set_pins(ADR, D1);
      local_addr = ADR;
      w0 = rx_words;
      drops = 0;
      transmit_request = 1'b1;
      wait_active(1'b1);
      repeat (1000) @(posedge clk);
      #1 set_pins(ADR, D2);
      n = 0;
      while (rx_words != w0 + 6 && n < 3 * CYC_CLK)
      begin
         @(posedge clk);
         #1;
         drops += (tx_active_q !== 1'b1);
         n++;
      end
      chk(drops, 0);
      chk(rx_data, D2);
      chk(rx_out, hi(D2));
      transmit_request = 1'b0;
      wait_active(1'b0);
      chk(rx_words - w0, 6);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10 * CYC_CLK)
      begin
         failures++;
         results();
      end
   end
   initial
   begin
      sys_rst = 1'b1;
      transmit_request = 1'b0;
      local_addr = ADR;
      set_pins(ADR, D1);
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      chk(tx_active_q, 1'b0);
      pulse_cycle(ADR, hi(D1));
      hold_cycles();
      pulse_cycle(ADR ^ 20'h1, hi(D2));
      results();
   end
endmodule
`default_nettype wire
